// ===== shared/imr_defines.vh
// Constants for the I2C master restart/transmit/receive engine
`ifndef IMR_DEFINES_VH
`define IMR_DEFINES_VH
// Register byte offsets (word aligned)
`define IMR_OFF_CTRL 4'h0
`define IMR_OFF_STAT 4'h4
`define IMR_OFF_BUF 4'h8
`define IMR_OFF_RATE 4'hc
// Control register fields
`define IMR_CTRL_RESTART 0
`define IMR_CTRL_RCV 1
`define IMR_CTRL_EN 2
`define IMR_CTRL_ACKVAL 3
// Status register fields
`define IMR_ST_BF 0
`define IMR_ST_ACK 1
`define IMR_ST_WRITE_COLLISION_FLAG 2
`define IMR_ST_OV 3
`define IMR_ST_START 4
`define IMR_ST_IRQ 5
`define IMR_ST_BCL 6
`define IMR_ST_BUSY 7
// Reset values
`define IMR_RATE_RST 8'h04
`define IMR_BYTE_RST 8'h00
// Bit counts: eight data bits, then the acknowledge slot
`define IMR_LAST_DATA 4'h7
`define IMR_ACK_SLOT 4'h8
// AHB encodings
`define IMR_HRESP_OKAY 1'b0
`endif

// ===== core/imr_rate_gen.v
// Reloadable rate generator that times each SCL half-period
`timescale 1ns/1ns
module imr_rate_gen
#(
	parameter W = 8
)
(
	// Clock and reset
	input wire clk,
	input wire rst,
	// Control
	input wire load,
	input wire run,
	input wire [W-1:0] reload,
	// Rollover pulse
	output wire tout
);
	reg [W-1:0] cnt_r; // Down counter
	reg [W-1:0] cnt_nxt;

	// Rollover when running and the count has reached zero
	assign tout = run & (cnt_r == {W{1'b0}});

	// Next count: load wins, rollover reloads, else count down
	always @*
	begin
		cnt_nxt = cnt_r;
		if (load)
			cnt_nxt = reload;
		else if (tout)
			cnt_nxt = reload;
		else if (run)
			cnt_nxt = cnt_r - {{(W-1){1'b0}}, 1'b1};
	end

	// Counter register
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			cnt_r <= {W{1'b0}};
		else
			cnt_r <= cnt_nxt;
	end
endmodule

// ===== core/imr_top.v
// I2C master engine: repeated start, byte transmit, byte receive
// Summary of operation
// - Restart when idle: SCL low, then count
// - Release SDA one period, then release SCL
// - SDA low one period, SCL low, clear
// - Start seen at once; flag after timeout
// - Restart write ignored while engine busy
// - Collision: SDA low at rise, early SCL
// - Buffer write sets full, starts transmission
// - Bit after SCL fall; low, high periods
// - Eighth fall clears full, releases SDA
// - Ninth clock captures slave acknowledge
// - After ninth: flag, suspend, SCL low
// - Busy buffer write dropped, collision flag
// - Receive enable ignored unless engine idle
// - Receive: each rollover toggles SCL; fall shifts
// - Eighth fall: copy byte, flags, suspend
// - Buffer read clears full in reception
// - Overflow when byte arrives with full set
// - Interrupt once restart condition completes
// - Generator always loads low eight bits
// - Generator paused until SCL sampled high
// - Collision sets flag, engine to idle
`timescale 1ns/1ns
`include "imr_defines.vh"
module imr_top
(
	// Clock and reset
	input wire clk,
	input wire rst,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg [31:0] hrdata,
	output reg hresp,
	// I2C clock line (open drain)
	input wire scl_i,
	output reg scl_o,
	output reg scl_oe,
	// I2C data line (open drain)
	input wire sda_i,
	output reg sda_o,
	output reg sda_oe
);
	// One-hot engine states
	localparam [10:0] S_IDLE = 11'h001;
	localparam [10:0] S_RS_LO = 11'h002; // SCL low, SDA released
	localparam [10:0] S_RS_REL = 11'h004; // SCL released, wait high
	localparam [10:0] S_RS_HI = 11'h008; // Both high one period
	localparam [10:0] S_RS_SDA = 11'h010; // SDA low, SCL high
	localparam [10:0] S_TX_LO = 11'h020;
	localparam [10:0] S_TX_REL = 11'h040;
	localparam [10:0] S_TX_HI = 11'h080;
	localparam [10:0] S_RX_LO = 11'h100;
	localparam [10:0] S_RX_REL = 11'h200;
	localparam [10:0] S_RX_HI = 11'h400;

	// Register address match, used by read and write decode
	function sel_reg;
		input [3:0] a;
		input [3:0] off;
		begin
			sel_reg = (a == off);
		end
	endfunction

	reg [10:0] state_r; // Engine state
	reg [1:0] sync0_r; // First synchroniser stage {scl,sda}
	reg [1:0] sync1_r; // Second stage, the sampled lines
	reg [1:0] prev_r; // Previous sample for edge detection
	reg restart_r; // restart_request_bit
	reg rcv_en_r; // receive_enable_bit
	reg port_en_r; // Port enable; low holds engine in reset
	reg ack_val_r; // ack_value_bit, stored and read back only
	reg [7:0] rate_r; // rate_reload_reg
	reg [7:0] buf_r; // transfer_buffer
	reg [7:0] shift_r; // shift_register
	reg [3:0] bit_r; // Bit slot within the byte
	reg bf_r; // buffer_full_flag
	reg ack_st_r; // ack_status_bit
	reg write_collision_flag_r; // write_collision_flag
	reg ov_r; // receive_overflow_flag
	reg start_r; // Start-seen status
	reg irq_r; // port_irq_flag
	reg bcl_r; // bus_collision_flag
	reg tx_mode_r; // Last byte was transmitted, not received
	reg wr_pend_r; // AHB write data phase pending
	reg [3:0] waddr_r; // Latched write address

	wire scl_s = sync1_r[1];
	wire sda_s = sync1_r[0];
	wire scl_fall = prev_r[1] & ~scl_s;
	wire sda_fall = prev_r[0] & ~sda_s;
	wire sda_rise = ~prev_r[0] & sda_s;
	wire busy = (state_r != S_IDLE);
	wire addr_ph = hsel & htrans[1] & hready;
	wire rd_ph = addr_ph & ~hwrite;
	wire [3:0] raddr = haddr[3:0];
	wire wr_ctrl = wr_pend_r & sel_reg(waddr_r, `IMR_OFF_CTRL);
	wire wr_stat = wr_pend_r & sel_reg(waddr_r, `IMR_OFF_STAT);
	wire wr_buf = wr_pend_r & sel_reg(waddr_r, `IMR_OFF_BUF);
	wire wr_rate = wr_pend_r & sel_reg(waddr_r, `IMR_OFF_RATE);
	wire rd_buf = rd_ph & sel_reg(raddr, `IMR_OFF_BUF);

	// Generator control: load holds the count while paused
	reg rg_load;
	reg rg_run;
	wire rg_tout;

	// Paused states keep reloading, so the high time restarts
	// from a full count once SCL is really seen high
	always @*
	begin
		rg_load = 1'b0;
		rg_run = 1'b0;
		case (state_r)
			// Transmit low time also counts only once SCL is seen low,
			// so each new bit is placed after the fall is observed
			S_RS_LO, S_TX_LO:
			begin
				rg_load = scl_s;
				rg_run = ~scl_s;
			end
			S_RS_REL, S_TX_REL, S_RX_REL:
				rg_load = 1'b1;
			S_RS_HI, S_RS_SDA, S_TX_HI, S_RX_LO, S_RX_HI:
				rg_run = 1'b1;
			default:
				rg_load = 1'b1;
		endcase
	end

	// Rate generator, fed from the low byte of the reload register
	imr_rate_gen #(.W(8)) u_rg
	(
		.clk(clk),
		.rst(rst),
		.load(rg_load),
		.run(rg_run),
		.reload(rate_r[7:0]),
		.tout(rg_tout)
	);

	// Two-stage synchronisers for both bus lines, plus history
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1)
		begin : g_sync
			always @(posedge clk or posedge rst)
			begin
				if (rst)
				begin
					sync0_r[gi] <= 1'b1;
					sync1_r[gi] <= 1'b1;
					prev_r[gi] <= 1'b1;
				end
				else
				begin
					sync0_r[gi] <= (gi == 1) ? scl_i : sda_i;
					sync1_r[gi] <= sync0_r[gi];
					prev_r[gi] <= sync1_r[gi];
				end
			end
		end
	endgenerate

	// AHB-Lite: zero wait states, reads answered from a flop
	// A write followed at once by a read of the same register
	// returns the value from before the write
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			hreadyout <= 1'b1;
			hresp <= `IMR_HRESP_OKAY;
			hrdata <= 32'h00000000;
			wr_pend_r <= 1'b0;
			waddr_r <= 4'h0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= `IMR_HRESP_OKAY;
			wr_pend_r <= addr_ph & hwrite;
			if (addr_ph)
				waddr_r <= haddr[3:0];
			if (rd_ph)
			begin
				// Unmapped addresses read zero
				hrdata <= 32'h00000000;
				if (sel_reg(raddr, `IMR_OFF_CTRL))
				begin
					hrdata[`IMR_CTRL_RESTART] <= restart_r;
					hrdata[`IMR_CTRL_RCV] <= rcv_en_r;
					hrdata[`IMR_CTRL_EN] <= port_en_r;
					hrdata[`IMR_CTRL_ACKVAL] <= ack_val_r;
				end
				else if (sel_reg(raddr, `IMR_OFF_STAT))
				begin
					hrdata[`IMR_ST_BF] <= bf_r;
					hrdata[`IMR_ST_ACK] <= ack_st_r;
					hrdata[`IMR_ST_WRITE_COLLISION_FLAG] <= write_collision_flag_r;
					hrdata[`IMR_ST_OV] <= ov_r;
					hrdata[`IMR_ST_START] <= start_r;
					hrdata[`IMR_ST_IRQ] <= irq_r;
					hrdata[`IMR_ST_BCL] <= bcl_r;
					hrdata[`IMR_ST_BUSY] <= busy;
				end
				else if (sel_reg(raddr, `IMR_OFF_BUF))
					hrdata[7:0] <= buf_r;
				else if (sel_reg(raddr, `IMR_OFF_RATE))
					hrdata[7:0] <= rate_r;
			end
		end
	end

	// Engine, flags and software-visible registers.
	// Hardware sets are written after software clears so that an
	// event in the clearing cycle is kept.
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_r <= S_IDLE;
			restart_r <= 1'b0;
			rcv_en_r <= 1'b0;
			port_en_r <= 1'b0;
			ack_val_r <= 1'b0;
			rate_r <= `IMR_RATE_RST;
			buf_r <= `IMR_BYTE_RST;
			shift_r <= `IMR_BYTE_RST;
			bit_r <= 4'h0;
			bf_r <= 1'b0;
			ack_st_r <= 1'b0;
			write_collision_flag_r <= 1'b0;
			ov_r <= 1'b0;
			start_r <= 1'b0;
			irq_r <= 1'b0;
			bcl_r <= 1'b0;
			tx_mode_r <= 1'b0;
			scl_o <= 1'b0;
			scl_oe <= 1'b0;
			sda_o <= 1'b0;
			sda_oe <= 1'b0;
		end
		else
		begin
			// Drive values stay low; only enables move
			scl_o <= 1'b0;
			sda_o <= 1'b0;
			// Software writes to plain registers
			if (wr_rate)
				rate_r <= hwdata[7:0];
			if (wr_ctrl)
			begin
				port_en_r <= hwdata[`IMR_CTRL_EN];
				ack_val_r <= hwdata[`IMR_CTRL_ACKVAL];
			end
			// Write-one-to-clear status flags
			if (wr_stat)
			begin
				if (hwdata[`IMR_ST_WRITE_COLLISION_FLAG])
					write_collision_flag_r <= 1'b0;
				if (hwdata[`IMR_ST_OV])
					ov_r <= 1'b0;
				if (hwdata[`IMR_ST_IRQ])
					irq_r <= 1'b0;
				if (hwdata[`IMR_ST_BCL])
					bcl_r <= 1'b0;
			end
			// Buffer read releases the full flag when receiving
			if (rd_buf & ~tx_mode_r)
				bf_r <= 1'b0;
			// Start and stop detection on the sampled lines
			if (sda_fall & scl_s)
				start_r <= 1'b1;
			else if (sda_rise & scl_s)
				start_r <= 1'b0;

			case (state_r)
				S_IDLE:
				begin
					if (wr_ctrl & hwdata[`IMR_CTRL_RESTART] &
						port_en_r)
					begin
						restart_r <= 1'b1;
						scl_oe <= 1'b1;
						sda_oe <= 1'b0;
						state_r <= S_RS_LO;
					end
					else if (wr_ctrl & hwdata[`IMR_CTRL_RCV] &
						port_en_r)
					begin
						rcv_en_r <= 1'b1;
						tx_mode_r <= 1'b0;
						bit_r <= 4'h0;
						scl_oe <= 1'b1;
						sda_oe <= 1'b0;
						state_r <= S_RX_LO;
					end
					else if (wr_buf & port_en_r)
					begin
						buf_r <= hwdata[7:0];
						bf_r <= 1'b1;
						tx_mode_r <= 1'b1;
						bit_r <= 4'h0;
						scl_oe <= 1'b1;
						sda_oe <= ~hwdata[7];
						shift_r <= hwdata[7:0]; // Current bit on top
						state_r <= S_TX_LO;
					end
				end
				S_RS_LO:
				begin
					// SDA sampled low at timeout: someone holds it
					if (rg_tout & ~sda_s)
						bcl_r <= 1'b1;
					else if (rg_tout)
					begin
						scl_oe <= 1'b0;
						state_r <= S_RS_REL;
					end
				end
				S_RS_REL:
				begin
					if (scl_s & ~sda_s)
						bcl_r <= 1'b1;
					else if (scl_s)
						state_r <= S_RS_HI;
				end
				S_RS_HI:
				begin
					// SCL dropped before we pulled SDA low
					if (scl_fall)
						bcl_r <= 1'b1;
					else if (rg_tout)
					begin
						sda_oe <= 1'b1;
						state_r <= S_RS_SDA;
					end
				end
				S_RS_SDA:
				begin
					if (rg_tout)
					begin
						scl_oe <= 1'b1;
						restart_r <= 1'b0;
						irq_r <= 1'b1;
						state_r <= S_IDLE;
					end
				end
				S_TX_LO:
				begin
					// Bit changes only once SCL is seen low, which
					// keeps the hold time after the fall
					if (~scl_s)
						sda_oe <= (bit_r == `IMR_ACK_SLOT) ?
							1'b0 : ~shift_r[7];
					// One cycle of set-up before SCL is released
					if (rg_tout & ~prev_r[1])
					begin
						scl_oe <= 1'b0;
						state_r <= S_TX_REL;
					end
				end
				S_TX_REL:
				begin
					if (scl_s)
					begin
						if (bit_r == `IMR_ACK_SLOT)
							ack_st_r <= sda_s;
						state_r <= S_TX_HI;
					end
				end
				S_TX_HI:
				begin
					// Released a one but the line reads zero
					if (~sda_oe & ~sda_s & (bit_r != `IMR_ACK_SLOT))
						bcl_r <= 1'b1;
					else if (rg_tout)
					begin
						scl_oe <= 1'b1;
						bit_r <= bit_r + 4'h1;
						if (bit_r == `IMR_ACK_SLOT)
						begin
							irq_r <= 1'b1;
							state_r <= S_IDLE;
						end
						else if (bit_r == `IMR_LAST_DATA)
						begin
							bf_r <= 1'b0;
							state_r <= S_TX_LO;
						end
						else
						begin
							// Next bit is driven from the low phase
							shift_r <= {shift_r[6:0], 1'b0};
							state_r <= S_TX_LO;
						end
					end
				end
				S_RX_LO:
				begin
					if (rg_tout)
					begin
						scl_oe <= 1'b0;
						state_r <= S_RX_REL;
					end
				end
				S_RX_REL:
				begin
					if (scl_s)
						state_r <= S_RX_HI;
				end
				S_RX_HI:
				begin
					if (rg_tout)
					begin
						scl_oe <= 1'b1;
						shift_r <= {shift_r[6:0], sda_s};
						bit_r <= bit_r + 4'h1;
						if (bit_r == `IMR_LAST_DATA)
						begin
							rcv_en_r <= 1'b0;
							buf_r <= {shift_r[6:0], sda_s};
							bf_r <= 1'b1;
							irq_r <= 1'b1;
							if (bf_r & ~(rd_buf & ~tx_mode_r))
								ov_r <= 1'b1;
							state_r <= S_IDLE;
						end
						else
							state_r <= S_RX_LO;
					end
				end
				default:
					state_r <= S_IDLE;
			endcase

			// Buffer write while busy is dropped
			if (wr_buf & busy)
				write_collision_flag_r <= 1'b1;
			// Control writes during activity have no effect; only
			// enable and ack value were stored above
			if (~busy & wr_ctrl & hwdata[`IMR_CTRL_RESTART])
				restart_r <= port_en_r;

			// Collision: release both lines, back to idle
			if ((state_r == S_RS_LO & rg_tout & ~sda_s) |
				(state_r == S_RS_REL & scl_s & ~sda_s) |
				(state_r == S_RS_HI & scl_fall) |
				(state_r == S_TX_HI & ~sda_oe & ~sda_s &
				(bit_r != `IMR_ACK_SLOT)))
			begin
				scl_oe <= 1'b0;
				sda_oe <= 1'b0;
				restart_r <= 1'b0;
				bf_r <= 1'b0;
				state_r <= S_IDLE;
			end

			// Port disabled: engine held in its reset state
			if (~port_en_r)
			begin
				state_r <= S_IDLE;
				scl_oe <= 1'b0;
				sda_oe <= 1'b0;
				restart_r <= 1'b0;
				rcv_en_r <= 1'b0;
				bf_r <= 1'b0;
				start_r <= 1'b0;
			end
		end
	end
endmodule

// ===== tb/imr_chk.sv
// Concurrent checks on the I2C master engine ports
`timescale 1ns/1ns
module imr_chk
(
	// Clock and reset
	input wire clk,
	input wire rst,
	// Register bus
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	input wire hreadyout,
	input wire [31:0] hrdata,
	input wire hresp,
	// Bus lines
	input wire scl_i,
	input wire scl_o,
	input wire scl_oe,
	input wire sda_i,
	input wire sda_o,
	input wire sda_oe
);
	// One domain, so clock and disable are given once
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// Pins may only ever pull low
	chk_pins_open: assert property (!scl_o && !sda_o)
		else $error("pin drives high");
	// Zero wait states, always OKAY
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	// Read data holds until the next read is taken
	chk_rdata_hold: assert property (
		!$past(hsel && htrans[1] && hready && !hwrite) |-> $stable(hrdata))
		else $error("read data moved without a read");
	// Lines released and read data clear after reset
	chk_rst_idle: assert property (
		$fell(rst) |-> !scl_oe && !sda_oe && hrdata == 32'h0)
		else $error("not idle after reset");
	// Clock pulled low only after a seen high time
	chk_scl_high: assert property (
		$rose(scl_oe) |-> $past(scl_i, 2) && $past(scl_i, 3))
		else $error("clock high time too short");
	// Clock low time lasts at least a few counts
	chk_scl_low: assert property (
		$fell(scl_oe) |-> $past(scl_oe, 2) && $past(scl_oe, 3))
		else $error("clock low time too short");
	// Data holds for two cycles after the clock is pulled low
	chk_sda_hold: assert property (
		$rose(scl_oe) |=> $stable(sda_oe) [*2])
		else $error("data moved right after clock fall");
	// Data released only while the clock is pulled low
	chk_sda_free: assert property ($fell(sda_oe) |-> $past(scl_oe))
		else $error("data released with clock high");
	// Data pulled with clock high only after both lines seen high
	chk_sda_start: assert property ($rose(sda_oe) |->
		$past(scl_oe) || ($past(scl_i, 2) && $past(sda_i, 2)))
		else $error("start without lines high");
	// Main scenarios
	cov_restart: cover property ($rose(sda_oe) && !scl_oe);
	cov_stretch: cover property ((!scl_oe && !scl_i) [*4]);
	cov_read: cover property (hsel && htrans[1] && !hwrite);
endmodule

// ===== tb/imr_slave_model.sv
// Behavioural I2C slave at the far side of the engine
`timescale 1ns/1ns
module imr_slave_model
(
	// Resolved bus lines
	input wire scl,
	input wire sda,
	// Scenario controls
	input wire ack_en,
	input wire rd,
	input wire stretch,
	input wire jam,
	input wire [7:0] tx_byte,
	// Pulls and captured byte
	output reg scl_pull,
	output wire sda_pull,
	output reg [7:0] rx_byte
);
	reg [3:0] cnt; // Clock rises since start
	reg drv; // Own data or ack pull
	// Jam fakes a competing master holding data low
	assign sda_pull = drv | jam;
	// Idle: nothing pulled
	initial
	begin
		cnt = 4'h0;
		drv = 1'b0;
		scl_pull = 1'b0;
		rx_byte = 8'h00;
	end
	// Start seen: bit count begins again
	always @(negedge sda)
		if (scl)
			cnt = 4'h0;
	// Sample on the rise, first bit is the top one
	always @(posedge scl)
	begin
		if (cnt < 4'h8)
			rx_byte = {rx_byte[6:0], sda};
		cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
	end
	// Change only after the fall; optional clock stretch
	always @(negedge scl)
	begin
		if (rd)
			drv = (cnt < 4'h8) ? ~tx_byte[4'h7 - cnt[2:0]] : 1'b0;
		else
			drv = (cnt == 4'h8) && ack_en;
		if (stretch)
		begin
			scl_pull = 1'b1;
			#300 scl_pull = 1'b0;
		end
	end
	// Reading: first bit must stand before the first rise
	always @(posedge rd)
	begin
		cnt = 4'h0;
		drv = ~tx_byte[7];
	end
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the I2C master engine
`timescale 1ns/1ns
`include "imr_defines.vh"
module tb_top;
	reg clk, rst, hsel, hwrite; // Clock, reset, bus controls
	reg [1:0] htrans;
	reg [31:0] haddr, hwdata, rd_d;
	reg ack_en, rd, stretch, jam; // Slave behaviour
	reg [7:0] tx_byte;
	wire hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe, s_scl, s_sda;
	wire [31:0] hrdata;
	wire [7:0] rx_byte;
	// Open drain with pull-ups
	wire scl = ~(scl_oe | s_scl);
	wire sda = ~(sda_oe | s_sda);
	integer miscompares, samples_checked, i, n, k;
	// Reset rows: address, expected read
	logic [63:0] rows [5] = '{{32'h0, 32'h0}, {32'h4, 32'h0},
		{32'h8, 24'h0, `IMR_BYTE_RST}, {32'hc, 24'h0, `IMR_RATE_RST},
		{32'h10, 32'h0}};
	imr_top u_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
		.sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
	imr_slave_model u_slv (.scl(scl), .sda(sda), .ack_en(ack_en),
		.rd(rd), .stretch(stretch), .jam(jam), .tx_byte(tx_byte),
		.scl_pull(s_scl), .sda_pull(s_sda), .rx_byte(rx_byte));
	// Verdict and end of run
	task final_report;
	begin
		if (miscompares == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	// A used-up wait counts as a mismatch
	task timeout;
	begin
		miscompares++;
		final_report;
	end
	endtask
	task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
	begin
		samples_checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	end
	endtask
	// Wait for ready sampled high, bounded
	task wait_rdy;
	begin
		k = 0;
		@(posedge clk);
		while (hreadyout !== 1'b1 && k < 50)
		begin
			k++;
			@(posedge clk);
		end
		if (k == 50)
			timeout;
	end
	endtask
	// One single transfer: address phase, then data phase
	task xfer(input w, input [31:0] a, input [31:0] d);
	begin
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wait_rdy;
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		wait_rdy;
		rd_d = hrdata;
	end
	endtask
	task chk(input string nm, input [31:0] a, input [31:0] e);
	begin
		xfer(1'b0, a, 32'h0);
		cmp(nm, e, rd_d);
	end
	endtask
	// Poll a status bit, bounded
	task wait_bit(input integer b);
	begin
		n = 0;
		xfer(1'b0, 32'h4, 32'h0);
		while (rd_d[b] !== 1'b1 && n < 300)
		begin
			n++;
			xfer(1'b0, 32'h4, 32'h0);
		end
		if (n == 300)
			timeout;
	end
	endtask
	// Receive one byte, check status, clear the flag
	task rx(input [7:0] b, input [31:0] e);
	begin
		tx_byte = b;
		rd = 1'b1;
		xfer(1'b1, 32'h0, 32'h6);
		wait_bit(5);
		rd = 1'b0;
		chk("rx_stat", 32'h4, e);
		xfer(1'b1, 32'h4, 32'h20);
	end
	endtask
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		{rst, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 68'h0};
		{ack_en, rd, stretch, jam, tx_byte} = {1'b1, 11'h0};
		miscompares = 0;
		samples_checked = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		// Reset values, one alias address among them
		for (i = 0; i < 5; i++)
			chk("reset", rows[i][63:32], rows[i][31:0]);
		xfer(1'b1, 32'hc, 32'h103);
		chk("rate", 32'hc, 32'h3);
		xfer(1'b1, 32'h0, 32'h4);
		// Repeated start
		xfer(1'b1, 32'h0, 32'h5);
		wait_bit(5);
		chk("stat", 32'h4, 32'h30);
		chk("ctrl", 32'h0, 32'h4);
		cmp("lines", 32'h3, {sda_oe, scl_oe});
		xfer(1'b1, 32'h4, 32'h20);
		// Address byte, second write and restart refused
		xfer(1'b1, 32'h8, 32'ha4);
		xfer(1'b1, 32'h8, 32'h11);
		xfer(1'b1, 32'h0, 32'h7);
		chk("stat", 32'h4, 32'h95);
		wait_bit(5);
		chk("stat", 32'h4, 32'h34);
		chk("ctrl", 32'h0, 32'h4);
		chk("buf", 32'h8, 32'ha4);
		cmp("rx", 32'ha4, rx_byte);
		cmp("scl", 32'h1, scl_oe);
		xfer(1'b1, 32'h4, 32'h24);
		// Data byte refused by a stretching slave
		{ack_en, stretch} = 2'b01;
		xfer(1'b1, 32'h8, 32'h5b);
		wait_bit(5);
		chk("stat", 32'h4, 32'h32);
		cmp("rx", 32'h5b, rx_byte);
		{ack_en, stretch} = 2'b10;
		xfer(1'b1, 32'h4, 32'h20);
		// New start, read address, three bytes in
		xfer(1'b1, 32'h0, 32'h5);
		wait_bit(5);
		xfer(1'b1, 32'h4, 32'h20);
		xfer(1'b1, 32'h8, 32'ha5);
		wait_bit(5);
		chk("stat", 32'h4, 32'h30);
		xfer(1'b1, 32'h4, 32'h20);
		rx(8'h3c, 32'h31);
		chk("ctrl", 32'h0, 32'h4);
		chk("buf", 32'h8, 32'h3c);
		chk("stat", 32'h4, 32'h10);
		rx(8'hc3, 32'h31);
		rx(8'h96, 32'h39);
		// Competing master holds data low during a restart
		xfer(1'b1, 32'h4, 32'h8);
		jam = 1'b1;
		xfer(1'b1, 32'h0, 32'h5);
		wait_bit(6);
		cmp("lines", 32'h0, {sda_oe, scl_oe});
		chk("ctrl", 32'h0, 32'h4);
		jam = 1'b0;
		final_report;
	end
endmodule
bind imr_top imr_chk u_chk (.clk(clk), .rst(rst), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
	.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hrdata(hrdata), .hresp(hresp), .scl_i(scl_i), .scl_o(scl_o),
	.scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));
